/* eer_pkg.sv */
// Constants, field layout and types for the ECC error reporting block.
// Assumes nothing of its surroundings; the files that use it refer to it by scope.
package eer_pkg;

	// ************************************************************
	// Word layout
	// ************************************************************
	localparam int unsigned WORD_W = 16;
	localparam int unsigned ADDR_W = 25;
	localparam int unsigned ST_OFF_BIT = 0;
	localparam int unsigned ST_DATA_BIT = 1;
	localparam int unsigned ST_ECC_BIT = 2;
	localparam int unsigned ST_CORR_BIT = 3;
	localparam int unsigned ST_DBL_BIT = 4;
	localparam logic [10:0] ST_RSVD_VAL = 11'h000;
	localparam logic [15:0] STATUS_RST = 16'h0000;
	localparam logic [15:0] TRAP_RST = 16'h0000;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CNT_ONE = 16'h0001;

	// ************************************************************
	// Trap fields
	// ************************************************************
	localparam int unsigned LO_MSB = 15;
	localparam int unsigned LO_LSB = 3;
	localparam logic [2:0] LO_PAD = 3'h0;
	localparam int unsigned HI_MSB = 24;
	localparam int unsigned HI_LSB = 16;
	localparam logic [6:0] HI_PAD = 7'h00;
	localparam logic [15:0] HI_MASK_128 = 16'h007F;
	localparam logic [15:0] HI_MASK_256 = 16'h00FF;
	localparam logic [15:0] HI_MASK_512 = 16'h01FF;

	// ************************************************************
	// Configuration bits
	// ************************************************************
	localparam int unsigned PROT_TRAP_SEL_BIT = 13;
	localparam int unsigned VCR_STALL_BIT = 2;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {
		EER_D128 = 2'h0,
		EER_D256 = 2'h1,
		EER_D512 = 2'h3
	} eer_density_e;

	typedef enum logic {
		EER_RUN = 1'h0,
		EER_STALL = 1'h1
	} eer_stall_e;

endpackage

/* eer_cnt_if.sv */
// Interface between the reporting logic and its error counter.
// Assumes both ends share ref_clk and the asynchronous rst_n.
`timescale 1ns/1ps
interface eer_cnt_if (
	input wire logic clk,
	input wire logic rst_n
);
	logic inc;
	logic clr;
	logic [15:0] count;

	modport owner (input clk, input rst_n, input inc, input clr,
		output count);
	modport user (output inc, output clr, input count);
endinterface

/* eer_sync.sv */
// Two-flop synchroniser for one pin level.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
module eer_sync #(
	parameter logic RST_VAL = 1'h0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);
	logic meta_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // eer_sync

/* eer_sat_counter.sv */
// Saturating 16-bit error counter behind the counter interface.
// Assumes inc and clr come from logic on the same clock.
`timescale 1ns/1ps
module eer_sat_counter (
	eer_cnt_if.owner cnt
);
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	wire at_max = (count_r == eer_pkg::CNT_MAX);

	// Clear beats increment; increment stops at the top value
	assign count_nxt = cnt.clr ? eer_pkg::CNT_RST :
		(cnt.inc && !at_max) ? 16'(count_r + eer_pkg::CNT_ONE) :
		count_r;
	assign cnt.count = count_r;

	always_ff @(posedge cnt.clk or negedge cnt.rst_n) begin
		if (!cnt.rst_n) begin
			count_r <= eer_pkg::CNT_RST;
		end else begin
			count_r <= count_nxt;
		end
	end
endmodule // eer_sat_counter

/* ecc_error_reporting.sv */
// ECC status word, failing-address trap, error counter and strobe stall.
// Assumes the decoder reports one pulse per checked half-page on ref_clk;
// link pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
module ecc_error_reporting #(
	parameter eer_pkg::eer_density_e DENSITY = eer_pkg::EER_D128
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic link_clk,
	input wire logic cs_n,
	input wire logic read_phase,
	input wire logic hp_valid,
	input wire logic stat_rd,
	input wire logic [24:0] hp_addr,
	input wire logic hp_off,
	input wire logic hp_data_fix,
	input wire logic hp_ecc_fix,
	input wire logic hp_double,
	input wire logic hp_multi_prog,
	input wire logic ded_enabled,
	input wire logic overlay_active,
	input wire logic ecc_overlay,
	input wire logic overlay_exit,
	input wire logic cnt_clr_cmd,
	input wire logic cnt_rd_cmd,
	input wire logic [15:0] protection_config_word,
	input wire logic [15:0] volatile_config_word,
	output logic [15:0] ecc_unit_status,
	output logic [15:0] fail_addr_low,
	output logic [15:0] fail_addr_high,
	output logic [15:0] err_count,
	output logic rwds_o,
	output logic rwds_oe_n
);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	// Reset values match the idle pin levels, so no false edge after reset
	logic cs_n_q;
	logic ck_q;

	eer_sync #(.RST_VAL(1'h1)) u_cs_sync (
		.clk(ref_clk),
		.rst_n(rst_n),
		.d(cs_n),
		.q(cs_n_q)
	);

	eer_sync #(.RST_VAL(1'h0)) u_ck_sync (
		.clk(ref_clk),
		.rst_n(rst_n),
		.d(link_clk),
		.q(ck_q)
	);

	wire cs_act = !cs_n_q;

	// ************************************************************
	// Event classification
	// ************************************************************
	// Largest density has no counter and traps double-bit errors only
	wire largest = (DENSITY == eer_pkg::EER_D512);
	wire chk_on = !(hp_multi_prog && !ded_enabled);
	wire stat_ok = stat_rd && ecc_overlay;
	wire arr_ev = hp_valid && chk_on;
	// A status read sets the flags but never feeds trap, counter or stall
	wire rd_ev = stat_ok && chk_on;
	wire any_ev = arr_ev || rd_ev;
	wire is_single = (hp_data_fix || hp_ecc_fix) && !hp_double;
	wire ev_single = any_ev && is_single;
	wire ev_double = any_ev && hp_double;
	wire arr_single = arr_ev && is_single;
	wire arr_double = arr_ev && hp_double;
	wire sel_single = !largest &&
		protection_config_word[eer_pkg::PROT_TRAP_SEL_BIT];
	wire trap_type = arr_double || (arr_single && sel_single);

	// ************************************************************
	// Global sticky flags
	// ************************************************************
	logic corr_r;
	logic dbl_r;
	logic corr_nxt;
	logic dbl_nxt;

	// A set in the exit cycle wins over the clear
	assign corr_nxt = ev_single || (corr_r && !overlay_exit);
	assign dbl_nxt = ev_double || (dbl_r && !overlay_exit);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			corr_r <= 1'h0;
		end else begin
			corr_r <= corr_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dbl_r <= 1'h0;
		end else begin
			dbl_r <= dbl_nxt;
		end
	end

	// ************************************************************
	// Status word
	// ************************************************************
	logic [15:0] status_r;
	logic [15:0] status_nxt;
	wire [15:0] status_word;

	assign status_word[15:5] = eer_pkg::ST_RSVD_VAL;
	assign status_word[eer_pkg::ST_DBL_BIT] = dbl_nxt;
	assign status_word[eer_pkg::ST_CORR_BIT] = corr_nxt;
	assign status_word[eer_pkg::ST_ECC_BIT] =
		chk_on && hp_ecc_fix && !hp_double;
	assign status_word[eer_pkg::ST_DATA_BIT] =
		chk_on && hp_data_fix && !hp_double;
	assign status_word[eer_pkg::ST_OFF_BIT] = hp_off;

	// A read in the exit cycle wins, so its own result is not lost
	assign status_nxt = stat_ok ? status_word :
		overlay_exit ? eer_pkg::STATUS_RST : status_r;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_r <= eer_pkg::STATUS_RST;
		end else begin
			status_r <= status_nxt;
		end
	end

	assign ecc_unit_status = status_r;

	// ************************************************************
	// Failing-address trap
	// ************************************************************
	logic trap_valid_r;
	logic [15:0] trap_lo_r;
	logic [15:0] trap_hi_r;
	wire [15:0] hi_mask;
	wire trap_free = !trap_valid_r || overlay_exit;
	wire trap_take = trap_type && trap_free;
	// Trap clears with the flags and only loads with a flag event
	wire trap_valid_nxt = trap_take ||
		(trap_valid_r && !overlay_exit);
	wire [15:0] lo_word = {hp_addr[eer_pkg::LO_MSB:eer_pkg::LO_LSB],
		eer_pkg::LO_PAD};
	wire [15:0] hi_word = {eer_pkg::HI_PAD,
		hp_addr[eer_pkg::HI_MSB:eer_pkg::HI_LSB]} & hi_mask;
	wire [15:0] trap_lo_nxt = trap_take ? lo_word :
		overlay_exit ? eer_pkg::TRAP_RST : trap_lo_r;
	wire [15:0] trap_hi_nxt = trap_take ? hi_word :
		overlay_exit ? eer_pkg::TRAP_RST : trap_hi_r;

	assign hi_mask = (DENSITY == eer_pkg::EER_D512) ? eer_pkg::HI_MASK_512 :
		(DENSITY == eer_pkg::EER_D256) ? eer_pkg::HI_MASK_256 :
		eer_pkg::HI_MASK_128;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			trap_valid_r <= 1'h0;
		end else begin
			trap_valid_r <= trap_valid_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			trap_lo_r <= eer_pkg::TRAP_RST;
		end else begin
			trap_lo_r <= trap_lo_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			trap_hi_r <= eer_pkg::TRAP_RST;
		end else begin
			trap_hi_r <= trap_hi_nxt;
		end
	end

	assign fail_addr_low = trap_lo_r;
	assign fail_addr_high = trap_hi_r;

	// ************************************************************
	// Error counter
	// ************************************************************
	eer_cnt_if u_cnt_if (
		.clk(ref_clk),
		.rst_n(rst_n)
	);

	// One pulse per half-page, stall or not
	assign u_cnt_if.inc = (arr_single || arr_double) &&
		!overlay_active && !largest;
	assign u_cnt_if.clr = cnt_clr_cmd && ecc_overlay && !largest;

	eer_sat_counter u_counter (
		.cnt(u_cnt_if.owner)
	);

	// Read value is held so the host sees one stable count per read
	logic [15:0] cnt_out_r;
	wire cnt_rd_ok = cnt_rd_cmd && ecc_overlay;
	wire [15:0] cnt_out_nxt = cnt_rd_ok ? u_cnt_if.count : cnt_out_r;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_out_r <= eer_pkg::CNT_RST;
		end else begin
			cnt_out_r <= cnt_out_nxt;
		end
	end

	assign err_count = cnt_out_r;

	// ************************************************************
	// Strobe stall
	// ************************************************************
	eer_pkg::eer_stall_e stall_r;
	eer_pkg::eer_stall_e stall_nxt;
	// Stall starts only while selected; deselect always releases it
	wire stall_en = !volatile_config_word[eer_pkg::VCR_STALL_BIT];

	always_comb begin
		stall_nxt = stall_r;
		unique case (stall_r)
			eer_pkg::EER_RUN: begin
				if (arr_double && cs_act && stall_en) begin
					stall_nxt = eer_pkg::EER_STALL;
				end
			end
			eer_pkg::EER_STALL: begin
				if (!cs_act) begin
					stall_nxt = eer_pkg::EER_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stall_r <= eer_pkg::EER_RUN;
		end else begin
			stall_r <= stall_nxt;
		end
	end

	// Normal strobe follows the sampled link clock during data output
	logic rwds_r;
	logic rwds_oe_n_r;
	wire stalled = (stall_nxt == eer_pkg::EER_STALL);
	// Enable is registered beside the data so both move on one edge
	wire drive = cs_act && (read_phase || stalled);
	wire rwds_nxt = stalled ? 1'h0 : ck_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rwds_r <= 1'h0;
		end else begin
			rwds_r <= rwds_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rwds_oe_n_r <= 1'h1;
		end else begin
			rwds_oe_n_r <= !drive;
		end
	end

	assign rwds_o = rwds_r;
	assign rwds_oe_n = rwds_oe_n_r;

endmodule // ecc_error_reporting

/* eer_asserts.sv */
// Port checker for the ECC error reporting block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module eer_asserts (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic hp_valid,
	input wire logic stat_rd,
	input wire logic hp_off,
	input wire logic hp_data_fix,
	input wire logic hp_ecc_fix,
	input wire logic hp_double,
	input wire logic hp_multi_prog,
	input wire logic ded_enabled,
	input wire logic ecc_overlay,
	input wire logic overlay_exit,
	input wire logic cnt_rd_cmd,
	input wire logic [15:0] volatile_config_word,
	input wire logic [15:0] ecc_unit_status,
	input wire logic [15:0] fail_addr_low,
	input wire logic [15:0] fail_addr_high,
	input wire logic [15:0] err_count,
	input wire logic rwds_o,
	input wire logic rwds_oe_n
);
	// ****
	// Properties
	// ****
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire logic take = stat_rd && ecc_overlay;
	wire logic chk_on = !(hp_multi_prog && !ded_enabled);
	a_rsvd_zero:
	assert property (ecc_unit_status[15:5] == 11'h000) else $error("reserved set");
	a_status_hold:
	assert property (!take && !overlay_exit |=> $stable(ecc_unit_status))
		else $error("status moved");
	a_off_bit:
	assert property (take |=> ecc_unit_status[0] == $past(hp_off))
		else $error("off bit");
	a_fix_bits:
	assert property (take && chk_on && !hp_double |=>
		ecc_unit_status[1] == $past(hp_data_fix)
		&& ecc_unit_status[2] == $past(hp_ecc_fix)) else $error("fix bits");
	a_corr_sticky:
	assert property (take && chk_on && !hp_double
		&& (hp_data_fix || hp_ecc_fix) |=> ecc_unit_status[3])
		else $error("corr flag");
	a_dbl_sticky:
	assert property (take && chk_on && hp_double |=> ecc_unit_status[4])
		else $error("double flag");
	a_exit_clear:
	assert property (overlay_exit && !take |=> ecc_unit_status == 16'h0000)
		else $error("exit clear");
	a_trap_clear:
	assert property (overlay_exit && !hp_valid |=> fail_addr_low == 16'h0000
		&& fail_addr_high == 16'h0000) else $error("trap clear");
	a_trap_pad:
	assert property (fail_addr_low[2:0] == 3'h0 && fail_addr_high[15:9] == 7'h00)
		else $error("trap pad");
	a_count_gate:
	assert property (!(cnt_rd_cmd && ecc_overlay) |=> $stable(err_count))
		else $error("count moved");
	a_stall_low:
	assert property (hp_valid && hp_double && chk_on && !volatile_config_word[2]
		&& !rwds_oe_n && !cs_n |=> !rwds_o && !rwds_oe_n) else $error("no stall");
endmodule // eer_asserts
bind ecc_error_reporting eer_asserts u_chk (.ref_clk, .rst_n, .cs_n, .hp_valid,
	.stat_rd, .hp_off, .hp_data_fix, .hp_ecc_fix, .hp_double, .hp_multi_prog,
	.ded_enabled, .ecc_overlay, .overlay_exit, .cnt_rd_cmd, .volatile_config_word,
	.ecc_unit_status, .fail_addr_low, .fail_addr_high, .err_count, .rwds_o,
	.rwds_oe_n);

/* eer_host_model.sv */
// Host bus controller model: frames, link clock, strobe stall watch.
// Assumes frame is held high by the bench for the length of a read.
`timescale 1ns/1ps
module eer_host_model (
	input wire logic frame,
	input wire logic rwds_o,
	input wire logic rwds_oe_n,
	output logic cs_n,
	output logic link_clk,
	output logic bus_err
);
	int quiet = 0;
	logic last = 1'h0;
	initial begin
		cs_n = 1'h1;
		link_clk = 1'h0;
		bus_err = 1'h0;
	end
	// Link clock runs only inside a frame
	always @(posedge frame) begin
		cs_n = 1'h0;
		bus_err = 1'h0;
		while (frame) begin
			#40 link_clk = 1'h1;
			#40 link_clk = 1'h0;
		end
		#40 cs_n = 1'h1;
	end
	// Bus error after more than 64 link clock edges without a strobe edge
	always @(link_clk) begin
		if (rwds_oe_n || rwds_o != last) quiet = 0;
		else quiet++;
		last = rwds_o;
		if (quiet > 64) bus_err = 1'h1;
	end
endmodule // eer_host_model

/* ecc_error_reporting_test.sv */
// Testbench for the ECC error reporting block.
// Assumes the host model drives cs_n and link_clk.
`timescale 1ns/1ps
module ecc_error_reporting_test;
	logic ref_clk, rst_n, read_phase, hp_valid, stat_rd, hp_off, hp_data_fix;
	logic hp_ecc_fix, hp_double, hp_multi_prog, ded_enabled, overlay_active;
	logic ecc_overlay, overlay_exit, cnt_clr_cmd, cnt_rd_cmd, frame;
	logic link_clk, cs_n, rwds_o, rwds_oe_n, bus_err;
	logic [24:0] hp_addr;
	logic [15:0] prot, vcr, ecc_unit_status, fail_addr_low, fail_addr_high;
	logic [15:0] err_count;
	logic [15:0] big_status, big_lo, big_hi, big_cnt;
	int fails = 0;
	int num_checks = 0;
	int cyc = 0;
	ecc_error_reporting DUT (.ref_clk, .rst_n, .link_clk, .cs_n, .read_phase,
		.hp_valid, .stat_rd, .hp_addr, .hp_off, .hp_data_fix, .hp_ecc_fix,
		.hp_double, .hp_multi_prog, .ded_enabled, .overlay_active, .ecc_overlay,
		.overlay_exit, .cnt_clr_cmd, .cnt_rd_cmd, .protection_config_word(prot),
		.volatile_config_word(vcr), .ecc_unit_status, .fail_addr_low,
		.fail_addr_high, .err_count, .rwds_o, .rwds_oe_n);
	eer_host_model host (.frame, .rwds_o, .rwds_oe_n, .cs_n, .link_clk, .bus_err);
	ecc_error_reporting #(.DENSITY(eer_pkg::EER_D512)) dut_big (.ref_clk,
		.rst_n, .link_clk, .cs_n, .read_phase, .hp_valid, .stat_rd, .hp_addr,
		.hp_off, .hp_data_fix, .hp_ecc_fix, .hp_double, .hp_multi_prog,
		.ded_enabled, .overlay_active, .ecc_overlay, .overlay_exit,
		.cnt_clr_cmd, .cnt_rd_cmd, .protection_config_word(prot),
		.volatile_config_word(vcr), .ecc_unit_status(big_status),
		.fail_addr_low(big_lo), .fail_addr_high(big_hi), .err_count(big_cnt),
		.rwds_o(), .rwds_oe_n());
	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end
	// ****
	// Tasks
	// ****
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic hp(input logic [24:0] a, input logic f, input logic d);
		@(posedge ref_clk);
		hp_valid <= 1'h1;
		hp_addr <= a;
		hp_data_fix <= f;
		hp_double <= d;
		@(posedge ref_clk);
		hp_valid <= 1'h0;
		hp_data_fix <= 1'h0;
		hp_double <= 1'h0;
	endtask
	task automatic rs(input logic [24:0] a, input logic [3:0] b,
		input logic [15:0] e);
		@(posedge ref_clk);
		stat_rd <= 1'h1;
		hp_addr <= a;
		{hp_double, hp_ecc_fix, hp_data_fix, hp_off} <= b;
		@(posedge ref_clk);
		stat_rd <= 1'h0;
		{hp_double, hp_ecc_fix, hp_data_fix, hp_off} <= 4'h0;
		#1 chk("status", e, ecc_unit_status);
		chk("big status", e, big_status);
	endtask
	task automatic rc(input logic [15:0] e);
		@(posedge ref_clk);
		cnt_rd_cmd <= 1'h1;
		@(posedge ref_clk);
		cnt_rd_cmd <= 1'h0;
		#1 chk("count", e, err_count);
		chk("big count", 16'h0000, big_cnt);
	endtask
	task automatic pulse(input logic ex);
		@(posedge ref_clk);
		if (ex) overlay_exit <= 1'h1;
		else cnt_clr_cmd <= 1'h1;
		@(posedge ref_clk);
		overlay_exit <= 1'h0;
		cnt_clr_cmd <= 1'h0;
		#1;
	endtask
	task automatic ov(input logic on);
		@(posedge ref_clk);
		ecc_overlay <= on;
		overlay_active <= on;
	endtask
	task automatic tchk(input logic [24:0] a);
		chk("trap low", {a[15:3], 3'h0}, fail_addr_low);
		chk("trap high", {9'h000, a[22:16]}, fail_addr_high);
	endtask
	task automatic stall_run(input logic v, input logic e);
		@(posedge ref_clk);
		vcr <= {13'h0000, v, 2'h0};
		frame <= 1'h1;
		read_phase <= 1'h1;
		repeat (40) @(posedge ref_clk);
		hp(25'h0000100, 1'h0, 1'h1);
		hp(25'h0000110, 1'h1, 1'h0);
		repeat (400) @(posedge ref_clk);
		chk("bus error", {15'h0000, e}, {15'h0000, bus_err});
		frame <= 1'h0;
		read_phase <= 1'h0;
		repeat (30) @(posedge ref_clk);
		#1 chk("strobe off", 16'h0001, {15'h0000, rwds_oe_n});
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 70000) begin
			fails++;
			complete_run();
		end
	end
	// ****
	// Sequence
	// ****
	initial begin
		{rst_n, read_phase, hp_valid, stat_rd, hp_off, hp_data_fix} = 6'h00;
		{hp_ecc_fix, hp_double, hp_multi_prog, overlay_active} = 4'h0;
		{ecc_overlay, overlay_exit, cnt_clr_cmd, cnt_rd_cmd, frame} = 5'h00;
		ded_enabled = 1'h1;
		hp_addr = 25'h0000000;
		prot = 16'h2000;
		vcr = 16'h0004;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'h1;
		repeat (2) @(posedge ref_clk);
		chk("status", 16'h0000, ecc_unit_status);
		hp(25'h0ABCDE7, 1'h1, 1'h0);
		hp(25'h0123450, 1'h0, 1'h1);
		ded_enabled <= 1'h0;
		hp_multi_prog <= 1'h1;
		hp(25'h0040000, 1'h0, 1'h1);
		ded_enabled <= 1'h1;
		hp_multi_prog <= 1'h0;
		overlay_active <= 1'h1;
		hp(25'h0040000, 1'h0, 1'h1);
		ov(1'h1);
		rs(25'h0000020, 4'h1, 16'h0019);
		tchk(25'h0ABCDE7);
		chk("big trap low", 16'h3450, big_lo);
		chk("big trap high", 16'h0012, big_hi);
		rc(16'h0002);
		rs(25'h0777770, 4'h4, 16'h001C);
		rs(25'h0000000, 4'h2, 16'h001A);
		pulse(1'h1);
		chk("status", 16'h0000, ecc_unit_status);
		rc(16'h0002);
		rs(25'h0000030, 4'h8, 16'h0010);
		ov(1'h0);
		pulse(1'h0);
		prot <= 16'h0000;
		hp(25'h0011110, 1'h1, 1'h0);
		hp(25'h1622220, 1'h0, 1'h1);
		ov(1'h1);
		rc(16'h0004);
		rs(25'h0000010, 4'h0, 16'h0018);
		tchk(25'h1622220);
		chk("big trap low", 16'h2220, big_lo);
		chk("big trap high", 16'h0162, big_hi);
		pulse(1'h0);
		rc(16'h0000);
		pulse(1'h1);
		ov(1'h0);
		stall_run(1'h1, 1'h0);
		stall_run(1'h0, 1'h1);
		ov(1'h1);
		rc(16'h0004);
		ov(1'h0);
		hp_data_fix <= 1'h1;
		hp_valid <= 1'h1;
		repeat (65540) @(posedge ref_clk);
		hp_valid <= 1'h0;
		hp_data_fix <= 1'h0;
		ov(1'h1);
		rc(16'hFFFF);
		@(posedge ref_clk);
		rst_n <= 1'h0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'h1;
		repeat (2) @(posedge ref_clk);
		chk("trap low", 16'h0000, fail_addr_low);
		rc(16'h0000);
		complete_run();
	end
endmodule // ecc_error_reporting_test
